// *** pcs_strobe_timing.sv ***
// pc-card address to strobe timing engine for areas 5 and 6
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "pcs_params.svh"
module pcs_strobe_timing
  import pcs_pkg::*;
#(
  parameter int CW = `PCS_CNT_W
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic reset_n,
  // manual reset and standby, same clock domain
  input wire logic manual_reset,
  input wire logic standby,
  // register port
  input wire logic [`PCS_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // cycle request from the bus controller
  input wire logic req_valid,
  input wire pcs_req_s req,
  output logic busy,
  output logic done,
  // pc-card pins
  output logic [25:0] card_addr,
  output logic card_addr_valid,
  output pcs_strobe_s card_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] timing_reg;
  logic [15:0] wait_reg;
  pcs_state_e state_reg;
  logic area6_reg;
  logic write_reg;

  // power-on reset only; manual reset and standby leave it alone
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timing_reg <= `PCS_TIMING_RESET;
    end else if (reg_wr && reg_addr == `PCS_OFS_TIMING) begin
      timing_reg <= reg_wdata & `PCS_TIMING_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wait_reg <= `PCS_WAIT_RESET;
    end else if (reg_wr && reg_addr == `PCS_OFS_WAIT) begin
      wait_reg <= reg_wdata & `PCS_WAIT_WMASK;
    end
  end

  logic [15:0] status_word;
  assign status_word = {11'h000, standby, write_reg, area6_reg, busy,
                        card_addr_valid};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PCS_OFS_TIMING: reg_rdata <= timing_reg;
        `PCS_OFS_WAIT: reg_rdata <= wait_reg;
        `PCS_OFS_STATUS: reg_rdata <= status_word;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // code extraction

  logic [2:0] a5_assert_code;
  logic [2:0] a6_assert_code;
  logic [2:0] a5_hold_code;
  logic [2:0] a6_hold_code;
  logic [3:0] a5_wait_code;
  logic [3:0] a6_wait_code;

  assign a5_assert_code = {timing_reg[`PCS_A5_TED2],
                           timing_reg[`PCS_A5_TED1],
                           timing_reg[`PCS_A5_TED0]};
  assign a6_assert_code = {timing_reg[`PCS_A6_TED2],
                           timing_reg[`PCS_A6_TED1],
                           timing_reg[`PCS_A6_TED0]};
  assign a5_hold_code = {timing_reg[`PCS_A5_TEH2],
                         timing_reg[`PCS_A5_TEH1],
                         timing_reg[`PCS_A5_TEH0]};
  assign a6_hold_code = {timing_reg[`PCS_A6_TEH2],
                         timing_reg[`PCS_A6_TEH1],
                         timing_reg[`PCS_A6_TEH0]};
  assign a5_wait_code = {timing_reg[`PCS_A5_WAIT_B3],
                         wait_reg[`PCS_WAIT_A5_LSB +: 3]};
  assign a6_wait_code = {timing_reg[`PCS_A6_WAIT_B3],
                         wait_reg[`PCS_WAIT_A6_LSB +: 3]};

  // inserted wait states for a four-bit wait code
  function automatic logic [CW-1:0] wait_states(input logic [3:0] code);
    logic [CW-1:0] w;
    w = '0;
    case (code)
      4'h0: w = CW'(0);
      4'h1: w = CW'(1);
      4'h2: w = CW'(2);
      4'h3: w = CW'(3);
      4'h4: w = CW'(4);
      4'h5: w = CW'(6);
      4'h6: w = CW'(8);
      4'h7: w = CW'(10);
      4'h8: w = CW'(12);
      4'h9: w = CW'(14);
      4'hA: w = CW'(18);
      4'hB: w = CW'(22);
      4'hC: w = CW'(26);
      4'hD: w = CW'(30);
      4'hE: w = CW'(34);
      default: w = CW'(38);
    endcase
    return w;
  endfunction

  // codes of the cycle in flight
  logic [2:0] cur_assert;
  logic [2:0] cur_hold;
  logic [CW-1:0] cur_waits;
  logic [2:0] new_assert;
  logic [CW-1:0] hold_val;

  assign new_assert = req.area6 ? a6_assert_code : a5_assert_code;
  assign cur_assert = area6_reg ? a6_assert_code : a5_assert_code;
  assign cur_hold = area6_reg ? a6_hold_code : a5_hold_code;
  assign cur_waits = area6_reg ? wait_states(a6_wait_code)
                               : wait_states(a5_wait_code);
  // one cycle goes to leaving the strobe phase, so hold loads one short
  assign hold_val = (cur_hold == 3'h0) ? '0 : CW'(cur_hold - 3'h1);

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  logic cnt_load;
  logic [CW-1:0] cnt_val;
  logic cnt_expired;
  logic start;
  logic abort;

  assign start = req_valid && !busy && !standby;
  // manual reset idles the engine but leaves the registers alone
  assign abort = manual_reset;

  pcs_delay_cnt #(
    .CW(CW)
  ) u_delay_cnt (
    .clk(clk),
    .reset_n(reset_n),
    .load(cnt_load),
    .load_val(cnt_val),
    .expired(cnt_expired)
  );

  // counter loads on start and at the end of the setup and strobe phases
  always_comb begin
    cnt_load = 1'b0;
    cnt_val = '0;
    case (state_reg)
      PCS_IDLE: begin
        cnt_load = start;
        cnt_val = CW'(new_assert);
      end
      PCS_SETUP: begin
        cnt_load = cnt_expired;
        cnt_val = cur_waits;
      end
      PCS_STROBE: begin
        cnt_load = cnt_expired;
        cnt_val = hold_val;
      end
      PCS_HOLD: begin
        cnt_load = 1'b0;
        cnt_val = '0;
      end
      default: begin
        cnt_load = 1'b0;
        cnt_val = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n || abort) begin
      state_reg <= PCS_IDLE;
    end else begin
      case (state_reg)
        PCS_IDLE: begin
          if (start) begin
            state_reg <= PCS_SETUP;
          end
        end
        PCS_SETUP: begin
          if (cnt_expired) begin
            state_reg <= PCS_STROBE;
          end
        end
        PCS_STROBE: begin
          if (cnt_expired) begin
            state_reg <= (cur_hold == 3'h0) ? PCS_IDLE : PCS_HOLD;
          end
        end
        PCS_HOLD: begin
          if (cnt_expired) begin
            state_reg <= PCS_IDLE;
          end
        end
        default: state_reg <= PCS_IDLE;
      endcase
    end
  end

  logic cycle_end;
  assign cycle_end = (state_reg == PCS_STROBE && cnt_expired
                      && cur_hold == 3'h0)
                     || (state_reg == PCS_HOLD && cnt_expired);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      area6_reg <= 1'b0;
      write_reg <= 1'b0;
    end else if (start) begin
      area6_reg <= req.area6;
      write_reg <= req.write;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || abort) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (cycle_end) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || abort) begin
      done <= 1'b0;
    end else begin
      done <= cycle_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address pins, switched on the rising edge

  always_ff @(posedge clk) begin
    if (!reset_n || abort) begin
      card_addr <= 26'h0000000;
      card_addr_valid <= 1'b0;
    end else if (start) begin
      card_addr <= req.addr;
      card_addr_valid <= 1'b1;
    end else if (cycle_end) begin
      card_addr_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe pins, switched on the falling edge for the half cycle

  logic strobe_on;
  assign strobe_on = (state_reg == PCS_SETUP && cnt_expired)
                     || (state_reg == PCS_STROBE && !cnt_expired);

  always_ff @(negedge clk) begin
    if (!reset_n || abort) begin
      card_strobe.oe_n <= 1'b1;
      card_strobe.we_n <= 1'b1;
    end else begin
      card_strobe.oe_n <= !(strobe_on && !write_reg);
      card_strobe.we_n <= !(strobe_on && write_reg);
    end
  end

endmodule

// *** pcs_params.svh ***
// offsets, field positions, reset values and timing counts for the strobe timer
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// register indices on the plain register port
`define PCS_ADDR_W 4
`define PCS_OFS_TIMING 4'h0
`define PCS_OFS_WAIT 4'h1
`define PCS_OFS_STATUS 4'h2

// timing register layout
`define PCS_TIMING_RESET 16'h0000
`define PCS_TIMING_WMASK 16'hCFFF
`define PCS_A6_WAIT_B3 15
`define PCS_A5_WAIT_B3 14
`define PCS_A5_TED2 11
`define PCS_A6_TED2 10
`define PCS_A5_TEH2 9
`define PCS_A6_TEH2 8
`define PCS_A5_TED1 7
`define PCS_A5_TED0 6
`define PCS_A6_TED1 5
`define PCS_A6_TED0 4
`define PCS_A5_TEH1 3
`define PCS_A5_TEH0 2
`define PCS_A6_TEH1 1
`define PCS_A6_TEH0 0

// wait register layout: low three wait bits per area
`define PCS_WAIT_RESET 16'h0077
`define PCS_WAIT_A5_LSB 0
`define PCS_WAIT_A6_LSB 4
`define PCS_WAIT_WMASK 16'h0077

// counter width, and bus clock half period and period in ns
`define PCS_CNT_W 6
`define PCS_HALF_NS 10
`define PCS_CLK_NS 20

`endif

// *** pcs_pkg.sv ***
// types shared by the pc-card strobe timer
package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_IDLE,
    PCS_SETUP,
    PCS_STROBE,
    PCS_HOLD
  } pcs_state_e;

  typedef struct packed {
    logic area6;
    logic write;
    logic [25:0] addr;
  } pcs_req_s;

  typedef struct packed {
    logic oe_n;
    logic we_n;
  } pcs_strobe_s;

endpackage

// *** pcs_delay_cnt.sv ***
// loadable down counter that flags when it has run out
`timescale 1ns/1ps
module pcs_delay_cnt #(
  parameter int CW = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic load,
  input wire logic [CW-1:0] load_val,
  // status
  output logic expired
);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign expired = (cnt_reg == '0);

endmodule

// *** pcs_strobe_timing_checker.sv ***
// concurrent checks on the pc-card strobe timer ports
`timescale 1ns/1ps
`include "pcs_params.svh"
module pcs_strobe_timing_checker
  import pcs_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic manual_reset,
  input wire logic standby,
  // register port and request
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic req_valid,
  input wire pcs_req_s req,
  // status and pins
  input wire logic busy,
  input wire logic done,
  input wire logic [25:0] card_addr,
  input wire logic card_addr_valid,
  input wire pcs_strobe_s card_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    req_valid && !busy && !standby && !manual_reset;
  endsequence
  sequence s_drop;
    $fell(card_addr_valid) && !$past(manual_reset);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_take_busy: assert property (s_take |=> busy && card_addr_valid
    && card_addr == $past(req.addr)) else $error("request not taken");
  a_refuse_standby: assert property (standby && !busy |=> !busy)
    else $error("cycle started in standby");
  a_busy_track: assert property (busy == card_addr_valid)
    else $error("busy and address valid differ");
  a_release_done: assert property (disable iff (!reset_n || manual_reset)
    s_drop |-> done) else $error("no done after address release");
  a_done_cause: assert property (done |-> !card_addr_valid
    && $past(card_addr_valid)) else $error("done without release");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_one_strobe: assert property (card_strobe.oe_n || card_strobe.we_n)
    else $error("both strobes asserted");
  a_strobe_addr: assert property (
    !(card_strobe.oe_n && card_strobe.we_n) |-> card_addr_valid)
    else $error("strobe without address");
  a_addr_stable: assert property (
    card_addr_valid && $past(card_addr_valid) |-> $stable(card_addr))
    else $error("address moved during cycle");
  a_manual_abort: assert property ($past(manual_reset) |-> !busy && !done)
    else $error("cycle survived manual reset");
endmodule
bind pcs_strobe_timing pcs_strobe_timing_checker u_chk (
  .clk(clk), .reset_n(reset_n), .manual_reset(manual_reset),
  .standby(standby), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .req_valid(req_valid), .req(req), .busy(busy), .done(done),
  .card_addr(card_addr), .card_addr_valid(card_addr_valid),
  .card_strobe(card_strobe)
);

// *** pcs_card_model.sv ***
// pc-card model that times strobe and address edges
`timescale 1ns/1ps
module pcs_card_model
  import pcs_pkg::*;
(
  // pins from the strobe timer
  input wire logic card_addr_valid,
  input wire pcs_strobe_s card_strobe,
  // measured times in ns
  output int setup_ns,
  output int width_ns,
  output int hold_ns,
  output logic last_we
);
  realtime t_addr = 0.0;
  realtime t_edge = 0.0;
  logic act;
  assign act = !(card_strobe.oe_n && card_strobe.we_n);
  always @(posedge card_addr_valid) t_addr = $realtime;
  always @(posedge act) begin
    setup_ns = int'($realtime - t_addr);
    last_we = !card_strobe.we_n;
    t_edge = $realtime;
  end
  always @(negedge act) begin
    width_ns = int'($realtime - t_edge);
    t_edge = $realtime;
  end
  always @(negedge card_addr_valid) hold_ns = int'($realtime - t_edge);
endmodule

// *** pcs_strobe_timing_tb.sv ***
// self-checking bench for the pc-card strobe timer
`timescale 1ns/1ps
`include "pcs_params.svh"
`define CHK_EQ(g, e) begin n_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module pcs_strobe_timing_tb
  import pcs_pkg::*;
;
  logic clk = 0, reset_n = 0, manual_reset = 0, standby = 0;
  logic [`PCS_ADDR_W-1:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata;
  logic reg_wr = 0, reg_rd = 0, req_valid = 0, busy, done, av, lw;
  pcs_req_s req = '0;
  pcs_strobe_s stb;
  logic [25:0] card_addr;
  int error_cnt = 0, n_checks = 0, su, wd, hd;
  pcs_strobe_timing DUT (.clk(clk), .reset_n(reset_n),
    .manual_reset(manual_reset), .standby(standby), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req), .busy(busy),
    .done(done), .card_addr(card_addr), .card_addr_valid(av),
    .card_strobe(stb));
  pcs_card_model CARD (.card_addr_valid(av), .card_strobe(stb),
    .setup_ns(su), .width_ns(wd), .hold_ns(hd), .last_we(lw));
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    @(negedge clk); `CHK_EQ(reg_rdata, e)
  endtask
  function logic [15:0] pk(input logic [2:0] a5d, a6d, a5h, a6h);
    return {4'h0, a5d[2], a6d[2], a5h[2], a6h[2], a5d[1:0], a6d[1:0],
      a5h[1:0], a6h[1:0]};
  endfunction
  // one card cycle, then compare the card's measured times
  task cyc(input logic a6, w, input int d, ww, h);
    int i;
    @(posedge clk); req_valid <= 1'b1; req <= {a6, w, 26'h15A5A5A};
    @(posedge clk); req_valid <= 1'b0;
    for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
    if (i == 300) begin
      error_cnt++;
      finish_test();
    end
    `CHK_EQ(su, d * 20 + 10)
    `CHK_EQ(wd, ww * 20)
    `CHK_EQ(hd, h * 20 + 10)
    `CHK_EQ(lw, w)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(`PCS_OFS_TIMING, 16'h0000);
    rd(`PCS_OFS_WAIT, 16'h0077);
    wr(`PCS_OFS_TIMING, 16'hFFFF);
    rd(`PCS_OFS_TIMING, 16'hCFFF);
    rd(4'hF, 16'h0000);
    wr(`PCS_OFS_WAIT, 16'hFFFF);
    rd(`PCS_OFS_WAIT, 16'h0077);
    wr(`PCS_OFS_WAIT, 16'h0000);
    for (k = 0; k < 8; k++) begin
      wr(`PCS_OFS_TIMING, pk(k[2:0], 3'(7 - k), 3'(7 - k), k[2:0]));
      cyc(1'b0, k[0], k, 1, 7 - k);
      cyc(1'b1, !k[0], 7 - k, 1, k);
    end
    // wait codes: area 5 two waits, area 6 twelve via the top wait bit
    wr(`PCS_OFS_WAIT, 16'h0002);
    wr(`PCS_OFS_TIMING, 16'h8000);
    cyc(1'b0, 1'b0, 0, 3, 0);
    cyc(1'b1, 1'b1, 0, 13, 0);
    // standby holds off a request, manual reset aborts the cycle
    @(posedge clk); standby <= 1'b1; req_valid <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk); `CHK_EQ(busy, 1'b0)
    rd(`PCS_OFS_STATUS, 16'h001C);
    @(posedge clk); standby <= 1'b0;
    @(posedge clk); req_valid <= 1'b0;
    repeat (3) @(posedge clk);
    manual_reset <= 1'b1;
    @(posedge clk); manual_reset <= 1'b0;
    @(negedge clk); `CHK_EQ(av, 1'b0)
    rd(`PCS_OFS_TIMING, 16'h8000);
    rd(`PCS_OFS_STATUS, 16'h000C);
    finish_test();
  end
endmodule
